// >>> verilog/rsx_params.svh
// constants for the rotate/swap/xor/direction-load datapath
`ifndef RSX_PARAMS_SVH
`define RSX_PARAMS_SVH
`define RSX_DATA_W 8
`define RSX_ADDR_W 5
`define RSX_FILE_DEPTH 32
`define RSX_DIR_PORT_ADDR 5'h06
`define RSX_ACC_RST 8'h00
`define RSX_DIR_RST 8'hff
`define RSX_FILE_RST 8'h00
`define RSX_FLAG_RST 1'b0
`define RSX_ZERO_BYTE 8'h00
`endif

// >>> verilog/rsx_pkg.sv
// types shared by the datapath files
`default_nettype none
package rsx_pkg;
  typedef enum logic [2:0] {
    op_none = 3'b000,
    rotate_right_carry_op = 3'b001,
    nibble_swap_op = 3'b010,
    direction_load_op = 3'b011,
    xor_literal_op = 3'b100,
    xor_file_op = 3'b101
  } op_t;

  typedef struct packed {
    op_t op;
    logic [4:0] faddr;
    logic dest_file;
    logic [7:0] literal;
  } instr_t;

  typedef struct packed {
    logic [7:0] result;
    logic carry_out;
    logic carry_we;
    logic zero_we;
    logic acc_we;
    logic file_we;
    logic dir_we;
  } alu_out_t;
endpackage
`default_nettype wire

// >>> verilog/rsx_alu.sv
// combinational operation unit for the datapath
`include "rsx_params.svh"
`timescale 1ns/1ps
`default_nettype none
module rsx_alu
(
  input wire rsx_pkg::instr_t instr,
  input wire logic instr_valid,
  input wire logic [7:0] acc,
  input wire logic [7:0] fval,
  input wire logic carry_in,
  output rsx_pkg::alu_out_t res
);
  always_comb
  begin
    res = '0;
    if (instr_valid)
    begin
      unique case (instr.op)
        rsx_pkg::rotate_right_carry_op:
        begin
          res.result = {carry_in, fval[7:1]};
          res.carry_out = fval[0];
          res.carry_we = 1'b1;
          res.acc_we = ~instr.dest_file;
          res.file_we = instr.dest_file;
        end
        rsx_pkg::nibble_swap_op:
        begin
          res.result = {fval[3:0], fval[7:4]};
          res.acc_we = ~instr.dest_file;
          res.file_we = instr.dest_file;
        end
        rsx_pkg::direction_load_op:
        begin
          res.result = acc;
          res.dir_we = (instr.faddr == `RSX_DIR_PORT_ADDR);
        end
        rsx_pkg::xor_literal_op:
        begin
          res.result = acc ^ instr.literal;
          res.zero_we = 1'b1;
          res.acc_we = 1'b1;
        end
        rsx_pkg::xor_file_op:
        begin
          res.result = acc ^ fval;
          res.zero_we = 1'b1;
          res.acc_we = ~instr.dest_file;
          res.file_we = instr.dest_file;
        end
        default:
        begin
          res = '0;
        end
      endcase
    end
  end
endmodule // rsx_alu
`default_nettype wire

// >>> verilog/rotate_swap_xor_direction_load_op_datapath.sv
// top of the rotate/swap/xor/direction-load datapath
// What this block does
// - rotate right moves the addressed file register one bit down through carry, changing only carry.
// - rotate right writes the accumulator when the destination bit is 0, else the file register.
// - nibble swap exchanges the two halves, writes accumulator or file register, and leaves flags alone.
// - direction load with operand 6 copies the accumulator into the port direction register, flags unchanged.
// - literal xor combines accumulator and literal into the accumulator and updates zero.
// - file xor combines accumulator and addressed file register and updates only zero.
// - file xor writes the accumulator when the destination bit is 0, else the file register.
`include "rsx_params.svh"
`timescale 1ns/1ps
`default_nettype none
module rotate_swap_xor_direction_load_op_datapath
#(
  parameter int FILE_DEPTH = `RSX_FILE_DEPTH
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire rsx_pkg::instr_t instr,
  output logic [7:0] acc_q,
  output logic carry_q,
  output logic zero_q,
  output logic [7:0] dir_q,
  output logic [7:0] file_rd_q
);
  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  logic [7:0] acc_r, acc_nxt;
  logic carry_r, carry_nxt;
  logic zero_r, zero_nxt;
  logic [7:0] dir_r, dir_nxt;
  logic [7:0] mem_r [FILE_DEPTH];
  logic [7:0] mem_nxt [FILE_DEPTH];
  logic [7:0] rd_r, rd_nxt;
  logic [7:0] fval;
  rsx_pkg::alu_out_t res;

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == `RSX_ZERO_BYTE);
  endfunction

  assign fval = mem_r[instr.faddr];

  rsx_alu u_alu
  (
    .instr(instr),
    .instr_valid(instr_valid),
    .acc(acc_r),
    .fval(fval),
    .carry_in(carry_r),
    .res(res)
  );

  // ----------------------------------------------------------
  // accumulator and status flags
  // ----------------------------------------------------------
  always_comb
  begin
    acc_nxt = acc_r;
    carry_nxt = carry_r;
    zero_nxt = zero_r;
    if (res.acc_we)
    begin
      acc_nxt = res.result;
    end
    if (res.carry_we)
    begin
      carry_nxt = res.carry_out;
    end
    if (res.zero_we)
    begin
      zero_nxt = is_zero(res.result);
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_r <= `RSX_ACC_RST;
      carry_r <= `RSX_FLAG_RST;
      zero_r <= `RSX_FLAG_RST;
    end
    else
    begin
      acc_r <= acc_nxt;
      carry_r <= carry_nxt;
      zero_r <= zero_nxt;
    end
  end

  // ----------------------------------------------------------
  // port direction register
  // ----------------------------------------------------------
  always_comb
  begin
    dir_nxt = dir_r;
    if (res.dir_we)
    begin
      dir_nxt = res.result;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dir_r <= `RSX_DIR_RST;
    end
    else
    begin
      dir_r <= dir_nxt;
    end
  end

  // ----------------------------------------------------------
  // file registers and read-back copy
  // ----------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < FILE_DEPTH; i++)
    begin
      mem_nxt[i] = mem_r[i];
    end
    if (res.file_we)
    begin
      mem_nxt[instr.faddr] = res.result;
    end
    rd_nxt = res.file_we ? res.result : fval;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_r <= `RSX_FILE_RST;
      for (int i = 0; i < FILE_DEPTH; i++)
      begin
        mem_r[i] <= `RSX_FILE_RST;
      end
    end
    else
    begin
      rd_r <= rd_nxt;
      for (int i = 0; i < FILE_DEPTH; i++)
      begin
        mem_r[i] <= mem_nxt[i];
      end
    end
  end

  assign acc_q = acc_r;
  assign carry_q = carry_r;
  assign zero_q = zero_r;
  assign dir_q = dir_r;
  assign file_rd_q = rd_r;

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  logic rot_go, swp_go, dir_go, xl_go, xf_go;
  assign rot_go = instr_valid && instr.op == rsx_pkg::rotate_right_carry_op;
  assign swp_go = instr_valid && instr.op == rsx_pkg::nibble_swap_op;
  assign dir_go = instr_valid && instr.op == rsx_pkg::direction_load_op;
  assign xl_go = instr_valid && instr.op == rsx_pkg::xor_literal_op;
  assign xf_go = instr_valid && instr.op == rsx_pkg::xor_file_op;

  // only the port direction operand loads the register
  logic dir6_go;
  assign dir6_go = dir_go && instr.faddr == `RSX_DIR_PORT_ADDR;

  AST_ROT_CARRY: assert property (rot_go |=>
    carry_q == $past(fval[0]) && zero_q == $past(zero_q))
    else $error("rotate carry wrong");
  AST_ROT_ACC: assert property (rot_go && !instr.dest_file |=>
    acc_q == {$past(carry_q), $past(fval[7:1])})
    else $error("rotate to accumulator wrong");
  AST_ROT_FILE: assert property (rot_go && instr.dest_file |=>
    acc_q == $past(acc_q))
    else $error("rotate touched accumulator");
  AST_ROT_FILE_RD: assert property (rot_go && instr.dest_file |=>
    file_rd_q == {$past(carry_q), $past(fval[7:1])})
    else $error("rotate to file wrong");
  AST_SWAP: assert property (swp_go && !instr.dest_file |=>
    acc_q == {$past(fval[3:0]), $past(fval[7:4])}
    && carry_q == $past(carry_q) && zero_q == $past(zero_q))
    else $error("swap wrong");
  AST_SWAP_FILE: assert property (swp_go && instr.dest_file |=>
    acc_q == $past(acc_q) && carry_q == $past(carry_q)
    && zero_q == $past(zero_q))
    else $error("swap to file touched accumulator or flags");
  AST_DIR: assert property (dir6_go |=>
    dir_q == $past(acc_q) && acc_q == $past(acc_q)
    && carry_q == $past(carry_q) && zero_q == $past(zero_q))
    else $error("direction load wrong");
  AST_DIR_OTHER: assert property (dir_go && !dir6_go |=>
    dir_q == $past(dir_q))
    else $error("direction load acted on another operand");
  AST_XORL: assert property (xl_go |=>
    acc_q == ($past(acc_q) ^ $past(instr.literal))
    && carry_q == $past(carry_q))
    else $error("literal xor wrong");
  AST_XORF_FLAGS: assert property (xf_go |=>
    carry_q == $past(carry_q) && zero_q == ($past(acc_q) == $past(fval)))
    else $error("file xor flags wrong");
  AST_XORF_ACC: assert property (xf_go && !instr.dest_file |=>
    acc_q == ($past(acc_q) ^ $past(fval)))
    else $error("file xor to accumulator wrong");
  AST_XORF_DEST: assert property (xf_go && instr.dest_file |=>
    acc_q == $past(acc_q))
    else $error("file xor touched accumulator");
  AST_ZERO: assert property (xl_go |=>
    zero_q == (acc_q == `RSX_ZERO_BYTE))
    else $error("zero flag wrong");

  COV_ROT: cover property (rot_go ##1 rot_go);
  COV_XOR_ZERO: cover property (xl_go ##1 zero_q);
  COV_DIR: cover property (dir_go);
  COV_SWAP_FILE: cover property (swp_go && instr.dest_file);
endmodule // rotate_swap_xor_direction_load_op_datapath
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the rotate/swap/xor/direction-load datapath
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk;
  logic resetn;
  logic instr_valid;
  rsx_pkg::instr_t instr;
  logic [7:0] acc_q;
  logic carry_q;
  logic zero_q;
  logic [7:0] dir_q;
  logic [7:0] file_rd_q;
  int errors;
  int checks;
  int m_acc;
  int m_c;
  int m_z;
  int m_dir;
  int m_rd;
  int m_file[32];

  rotate_swap_xor_direction_load_op_datapath dut
  (
    .core_clk(core_clk),
    .resetn(resetn),
    .instr_valid(instr_valid),
    .instr(instr),
    .acc_q(acc_q),
    .carry_q(carry_q),
    .zero_q(zero_q),
    .dir_q(dir_q),
    .file_rd_q(file_rd_q)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_all();
    cmp(acc_q, m_acc[7:0]);
    cmp({7'h00, carry_q}, m_c[7:0]);
    cmp({7'h00, zero_q}, m_z[7:0]);
    cmp(dir_q, m_dir[7:0]);
  endtask

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic do_reset();
    resetn = 1'b0;
    instr_valid = 1'b0;
    repeat (5) @(posedge core_clk);
    #1 resetn = 1'b1;
    m_acc = 0;
    m_c = 0;
    m_z = 0;
    m_dir = 8'hff;
    m_rd = 0;
    foreach (m_file[j]) m_file[j] = 0;
    check_all();
    cmp(file_rd_q, 8'h00);
  endtask

  task automatic step(input logic v, input logic [2:0] code,
                      input logic [4:0] fa, input logic d,
                      input logic [7:0] k);
    int r;
    int f;
    instr_valid = v;
    instr.op = rsx_pkg::op_t'(code);
    instr.faddr = fa;
    instr.dest_file = d;
    instr.literal = k;
    @(posedge core_clk);
    #1;
    f = m_file[fa];
    r = -1;
    if (v)
      case (code)
        3'h1:
        begin
          r = (m_c << 7) | (f >> 1);
          m_c = f & 1;
        end
        3'h2: r = ((f & 15) << 4) | (f >> 4);
        3'h3: if (fa == 5'h06) m_dir = m_acc;
        3'h4:
        begin
          m_acc = m_acc ^ k;
          m_z = (m_acc == 0);
        end
        3'h5:
        begin
          r = m_acc ^ f;
          m_z = (r == 0);
        end
        default: ;
      endcase
    if (r >= 0 && d)
      m_file[fa] = r;
    else if (r >= 0)
      m_acc = r;
    check_all();
    if (v)
      cmp(file_rd_q, 8'(m_file[fa]));
  endtask

  initial
  begin
    #20000;
    errors++;
    $display("watchdog expired");
    give_verdict();
  end

  initial
  begin
    errors = 0;
    checks = 0;
    resetn = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    void'($urandom(32'hac8a34f7));
    do_reset();
    for (int i = 0; i < 32; i++)
    begin
      step(1'b1, 3'h4, 5'(i), 1'b0, 8'($urandom));
      step(1'b1, 3'h5, 5'(i), 1'b1, 8'h00);
    end
    $display("test fill done");
    repeat (600)
      step(1'b1, 3'($urandom), 5'($urandom), 1'($urandom), 8'($urandom));
    $display("test random done");
    step(1'b1, 3'h4, 5'h00, 1'b0, m_acc[7:0]);
    step(1'b1, 3'h4, 5'h00, 1'b0, 8'h5a);
    step(1'b1, 3'h3, 5'h06, 1'b0, 8'h00);
    step(1'b1, 3'h4, 5'h00, 1'b0, 8'hff);
    step(1'b1, 3'h3, 5'h07, 1'b0, 8'h00);
    $display("test direction done");
    repeat (4)
      step(1'b0, 3'($urandom), 5'($urandom), 1'($urandom), 8'($urandom));
    do_reset();
    step(1'b1, 3'h1, 5'h03, 1'b0, 8'h00);
    $display("test idle and reset done");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
